// >>> logic/exec_pkg.sv
// Shared constants, enumerations and state records for the two-instruction executor
package exec_pkg;

   // ----------------------------------------------------------------
   // Instruction encodings and field positions
   // ----------------------------------------------------------------
   localparam logic [15:0] OPC_KICK      = 16'h0004;  // Watchdog kick, full word
   localparam logic [15:0] OPC_INV_MASK  = 16'hFC00;  // Opcode bits of invert
   localparam logic [15:0] OPC_INV_VAL   = 16'h1C00;  // Invert opcode value
   localparam int          DEST_BIT      = 9;         // Destination select bit
   localparam int          ACC_BIT       = 8;         // Bank access select bit
   localparam int          SIGN_BIT      = 7;         // Sign bit of a data byte

   // ----------------------------------------------------------------
   // Addressing constants
   // ----------------------------------------------------------------
   localparam logic [7:0]  INDEX_LIMIT   = 8'h5F;     // Last indexed offset
   localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;     // Access bank upper half
   localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;      // Bank of lower half
   localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;      // Bank of upper half

   // ----------------------------------------------------------------
   // Register port offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0]  REG_CTRL      = 4'h0;      // Bit 0: extended set on
   localparam logic [3:0]  REG_BANK      = 4'h1;      // Bank pointer, low nibble
   localparam logic [3:0]  REG_WORK      = 4'h2;      // Working register
   localparam logic [3:0]  REG_STATUS    = 4'h3;      // N, Z, expired, slept
   localparam logic [3:0]  REG_WDOG      = 4'h4;      // Watchdog count
   localparam logic [3:0]  REG_WPOST     = 4'h5;      // Watchdog postscaler
   localparam int          ST_NEG        = 0;         // Status bit positions
   localparam int          ST_ZERO       = 1;
   localparam int          ST_EXPIRED    = 2;
   localparam int          ST_SLEPT      = 3;
   localparam logic        FLAG_RST      = 1'b1;      // Expired/slept after reset

   // ----------------------------------------------------------------
   // Watchdog sizes
   // ----------------------------------------------------------------
   localparam int          WDOG_CNT_W    = 8;
   localparam int          WDOG_POST_W   = 4;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
   typedef enum logic [1:0] {OP_NONE, OP_KICK, OP_INV}   op_kind_t;

   // Data memory request carried as one record
   typedef struct packed {
      logic [11:0] addr;
      logic        rd;
      logic        we;
      logic [7:0]  wdata;
   } mem_req_t;

   // Complete state of the executor
   typedef struct packed {
      phase_t      phase;
      op_kind_t    kind;
      logic        dest_w;
      logic [7:0]  result;
      logic [7:0]  wreg;
      logic        neg;
      logic        zero;
      logic        expired;
      logic        slept;
      logic        kick;
      mem_req_t    mem;
      logic [7:0]  rdata;
      logic        ext_en;
      logic [3:0]  bank;
   } exec_state_t;

endpackage : exec_pkg

// >>> logic/watchdog_core.sv
// Watchdog counter with postscaler and synchronous clear
`timescale 1ns/100ps
module watchdog_core #(
   parameter int CNT_W  = exec_pkg::WDOG_CNT_W,
   parameter int POST_W = exec_pkg::WDOG_POST_W
) (
   input  wire logic              core_clk_i,
   input  wire logic              srst_i,
   input  wire logic              clear_i,    // Restart a timeout period
   output logic [CNT_W-1:0]       count_o,
   output logic [POST_W-1:0]      post_o,
   output logic                   timeout_o   // One-cycle pulse
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (CNT_W < 1 || CNT_W > 8 || POST_W < 1 || POST_W > 8) begin : g_bad
      $error("watchdog_core: widths must lie in 1..8");
   end

   // State record
   typedef struct packed {
      logic [CNT_W-1:0]  cnt;
      logic [POST_W-1:0] post;
      logic              tout;
   } wdog_state_t;

   wdog_state_t st_r;   // Registered state
   wdog_state_t st_nxt; // Next state

   // Count, carry into the postscaler, pulse at full wrap
   always_comb begin
      st_nxt      = st_r;
      st_nxt.tout = 1'b0;
      if (clear_i) begin
         // Kick clears both stages
         st_nxt.cnt  = '0;
         st_nxt.post = '0;
      end else begin
         st_nxt.cnt = st_r.cnt + 1'b1;
         if (&st_r.cnt) begin
            st_nxt.post = st_r.post + 1'b1;
            st_nxt.tout = &st_r.post;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign count_o   = st_r.cnt;
   assign post_o    = st_r.post;
   assign timeout_o = st_r.tout;

   // Kick leaves counter and postscaler at zero
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   wdog_zero_a : assert property (clear_i |=> count_o == '0 && post_o == '0)
      else $error("watchdog not zero after kick");

endmodule : watchdog_core

// >>> logic/kick_invert_exec.sv
// Executor for the watchdog kick and file invert instructions
`timescale 1ns/100ps
module kick_invert_exec #(
   parameter int CNT_W  = exec_pkg::WDOG_CNT_W,
   parameter int POST_W = exec_pkg::WDOG_POST_W
) (
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   // Decode pipeline
   input  wire logic        instr_valid_i,  // Instruction offered in Q1
   input  wire logic [15:0] instr_i,        // Instruction word
   output logic             phase_q1_o,     // Executor is in Q1
   input  wire logic [11:0] index_base_i,   // Base pointer for indexed offsets
   // Data memory
   output exec_pkg::mem_req_t mem_req_o,    // Address, read, write, data
   input  wire logic [7:0]  mem_rdata_i,    // Read data, cycle after read
   // Register port
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [7:0]       reg_rdata_o,
   // Status outputs
   output logic [7:0]       work_o,         // Working register
   output logic             neg_o,
   output logic             zero_o,
   output logic             watchdog_expired_flag_o,
   output logic             sleep_entered_flag_o,
   output logic             watchdog_timeout_o
);

   // ----------------------------------------------------------------
   // State and watchdog
   // ----------------------------------------------------------------
   exec_pkg::exec_state_t st_r;     // Registered state
   exec_pkg::exec_state_t st_nxt;   // Next state
   logic [CNT_W-1:0]      wd_cnt;   // Watchdog count
   logic [POST_W-1:0]     wd_post;  // Watchdog postscaler
   logic                  wd_tout;  // Watchdog timeout pulse
   logic [7:0]            inv_byte; // Complemented read byte
   logic [7:0]            f_op;     // File operand of offered word

   watchdog_core #(
      .CNT_W  (CNT_W),
      .POST_W (POST_W)
   ) u_wdog (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .clear_i    (st_r.kick),
      .count_o    (wd_cnt),
      .post_o     (wd_post),
      .timeout_o  (wd_tout)
   );

   assign f_op     = instr_i[7:0];
   assign inv_byte = ~mem_rdata_i;

   // Resolve the file address of the offered word
   function automatic logic [11:0] file_addr(input logic acc, input logic [7:0] f,
                                            input logic ext, input logic [3:0] bank,
                                            input logic [11:0] base);
      logic [11:0] a;
      a = {bank, f};
      if (!acc) begin
         if (ext && f <= exec_pkg::INDEX_LIMIT) begin
            a = 12'(base + {exec_pkg::ACCESS_LO_BNK, f});
         end else if (f < exec_pkg::ACCESS_SPLIT) begin
            a = {exec_pkg::ACCESS_LO_BNK, f};
         end else begin
            a = {exec_pkg::ACCESS_HI_BNK, f};
         end
      end
      return a;
   endfunction : file_addr

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt           = st_r;
      st_nxt.mem.rd    = 1'b0;
      st_nxt.mem.we    = 1'b0;
      st_nxt.kick      = 1'b0;
      st_nxt.rdata     = 8'h00;
      // Timeout drops the expired flag
      if (wd_tout) begin
         st_nxt.expired = 1'b0;
      end
      unique case (st_r.phase)
         // Decode; start the file read for invert
         exec_pkg::PH_Q1: begin
            st_nxt.phase = exec_pkg::PH_Q2;
            st_nxt.kind  = exec_pkg::OP_NONE;
            if (instr_valid_i && instr_i == exec_pkg::OPC_KICK) begin
               st_nxt.kind = exec_pkg::OP_KICK;
            end else if (instr_valid_i &&
                         (instr_i & exec_pkg::OPC_INV_MASK) == exec_pkg::OPC_INV_VAL) begin
               st_nxt.kind     = exec_pkg::OP_INV;
               st_nxt.dest_w   = instr_i[exec_pkg::DEST_BIT];
               st_nxt.mem.rd   = 1'b1;
               st_nxt.mem.addr = file_addr(instr_i[exec_pkg::ACC_BIT], f_op,
                                           st_r.ext_en, st_r.bank, index_base_i);
            end
         end
         // Read cycle on the memory port
         exec_pkg::PH_Q2: begin
            st_nxt.phase = exec_pkg::PH_Q3;
            if (st_r.kind == exec_pkg::OP_KICK) begin
               st_nxt.kick = 1'b1;
            end
         end
         // Process data
         exec_pkg::PH_Q3: begin
            st_nxt.phase = exec_pkg::PH_Q4;
            if (st_r.kind == exec_pkg::OP_KICK) begin
               // Kick sets both flags, winning over a timeout
               st_nxt.expired = 1'b1;
               st_nxt.slept   = 1'b1;
            end else if (st_r.kind == exec_pkg::OP_INV) begin
               st_nxt.result    = inv_byte;
               st_nxt.mem.we    = !st_r.dest_w;
               st_nxt.mem.wdata = inv_byte;
            end
         end
         // Write to destination and flags
         exec_pkg::PH_Q4: begin
            st_nxt.phase = exec_pkg::PH_Q1;
            if (st_r.kind == exec_pkg::OP_INV) begin
               if (st_r.dest_w) begin
                  st_nxt.wreg = st_r.result;
               end
               st_nxt.neg  = st_r.result[exec_pkg::SIGN_BIT];
               st_nxt.zero = (st_r.result == 8'h00);
            end
         end
      endcase
      // Register port writes
      if (reg_wr_i) begin
         if (reg_addr_i == exec_pkg::REG_CTRL) begin
            st_nxt.ext_en = reg_wdata_i[0];
         end else if (reg_addr_i == exec_pkg::REG_BANK) begin
            st_nxt.bank = reg_wdata_i[3:0];
         end
      end
      // Register port reads, data stands one cycle later
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            exec_pkg::REG_CTRL:   st_nxt.rdata = {7'h00, st_r.ext_en};
            exec_pkg::REG_BANK:   st_nxt.rdata = {4'h0, st_r.bank};
            exec_pkg::REG_WORK:   st_nxt.rdata = st_r.wreg;
            exec_pkg::REG_STATUS: st_nxt.rdata = {4'h0, st_r.slept, st_r.expired,
                                                  st_r.zero, st_r.neg};
            exec_pkg::REG_WDOG:   st_nxt.rdata = 8'(wd_cnt);
            exec_pkg::REG_WPOST:  st_nxt.rdata = 8'(wd_post);
            default:              st_nxt.rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         st_r         <= '0;
         st_r.phase   <= exec_pkg::PH_Q1;
         st_r.expired <= exec_pkg::FLAG_RST;
         st_r.slept   <= exec_pkg::FLAG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign phase_q1_o              = (st_r.phase == exec_pkg::PH_Q1);
   assign mem_req_o               = st_r.mem;
   assign reg_rdata_o             = st_r.rdata;
   assign work_o                  = st_r.wreg;
   assign neg_o                   = st_r.neg;
   assign zero_o                  = st_r.zero;
   assign watchdog_expired_flag_o = st_r.expired;
   assign sleep_entered_flag_o    = st_r.slept;
   assign watchdog_timeout_o      = wd_tout;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   logic inv_q1;   // Invert offered in Q1
   assign inv_q1 = phase_q1_o && instr_valid_i &&
                   (instr_i & exec_pkg::OPC_INV_MASK) == exec_pkg::OPC_INV_VAL;

   invert_value_a : assert property (
      inv_q1 |=> ##1 st_r.mem.rd == 1'b0 ##1 st_r.result == ~$past(mem_rdata_i))
      else $error("invert result not complement of read byte");
   dest_file_a : assert property (
      inv_q1 && !instr_i[exec_pkg::DEST_BIT] |=> ##2
         mem_req_o.we && mem_req_o.wdata == ~$past(mem_rdata_i) && work_o == $past(work_o, 3))
      else $error("file destination not written");
   dest_work_a : assert property (
      inv_q1 && instr_i[exec_pkg::DEST_BIT] |=> !mem_req_o.we [*3] ##1
         work_o == $past(st_r.result))
      else $error("working destination not written");
   bank_addr_a : assert property (
      inv_q1 && instr_i[exec_pkg::ACC_BIT] |=>
         mem_req_o.rd && mem_req_o.addr == {$past(st_r.bank), $past(f_op)})
      else $error("banked address wrong");
   index_addr_a : assert property (
      inv_q1 && !instr_i[exec_pkg::ACC_BIT] && st_r.ext_en &&
         f_op <= exec_pkg::INDEX_LIMIT |=>
         mem_req_o.addr == 12'($past(index_base_i) + $past(f_op)))
      else $error("indexed address wrong");
   kick_count_a : assert property (
      phase_q1_o && instr_valid_i && instr_i == exec_pkg::OPC_KICK |=> ##2 wd_cnt == '0)
      else $error("kick did not clear counter");
   kick_flags_a : assert property (
      phase_q1_o && instr_valid_i && instr_i == exec_pkg::OPC_KICK |=> ##2
         wd_post == '0 && watchdog_expired_flag_o && sleep_entered_flag_o)
      else $error("kick flags or postscaler wrong");
   nz_flags_a : assert property (
      st_r.phase == exec_pkg::PH_Q4 && st_r.kind == exec_pkg::OP_INV |=>
         neg_o == $past(st_r.result[exec_pkg::SIGN_BIT]) &&
         zero_o == ($past(st_r.result) == 8'h00))
      else $error("negative or zero flag wrong");

   cov_inv_file_c  : cover property (inv_q1 && !instr_i[exec_pkg::DEST_BIT]);
   cov_inv_work_c  : cover property (inv_q1 && instr_i[exec_pkg::DEST_BIT]);
   cov_kick_c      : cover property (st_r.kick);
   cov_timeout_c   : cover property (wd_tout);

endmodule : kick_invert_exec

// >>> dv/data_mem_model.sv
// Data memory model that answers the executor's read and write requests
`timescale 1ns/100ps
module data_mem_model (
   input  wire exec_pkg::mem_req_t req_i,
   input  wire logic               core_clk_i,
   output logic [7:0]              rdata_o
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] mem_r [0:4095];   // Byte array, preloaded by the bench
   initial rdata_o = 8'h00;

   // Synchronous read with one cycle of latency; writes land at the edge
   always @(posedge core_clk_i) begin
      if (req_i.rd) begin
         rdata_o <= mem_r[req_i.addr];
      end else begin
         rdata_o <= ~rdata_o;    // Stale data keeps changing, never mistaken for valid
      end
      if (req_i.we) begin
         mem_r[req_i.addr] <= req_i.wdata;
      end
   end
endmodule : data_mem_model

// >>> dv/test_watchdog_clear_and_complement_exec.sv
// Self-checking bench for the kick and invert executor
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_watchdog_clear_and_complement_exec;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic               core_clk_i = 1'b0;
   logic               srst_i = 1'b1;
   logic               instr_valid_i = 1'b0;
   logic [15:0]        instr_i = 16'h0000;
   logic [11:0]        index_base_i = 12'h200;   // Base for indexed offsets
   logic [3:0]         reg_addr_i = 4'h0;
   logic [7:0]         reg_wdata_i = 8'h00;
   logic               reg_wr_i = 1'b0;
   logic               reg_rd_i = 1'b0;
   logic               phase_q1_o, neg_o, zero_o, exp_o, slp_o, wto_o;
   logic [7:0]         reg_rdata_o, work_o, mem_rdata_i, rd_v, exp_w, dat, exp_f;
   exec_pkg::mem_req_t mem_req_o;
   int                 error_cnt = 0;
   int                 checks_done = 0;
   int                 cyc = 0;
   int                 tout_seen = 0;            // Watchdog timeout pulses seen
   // Invert cases: word, extended set, resolved address, file data
   localparam logic [15:0] T_INS [0:6] = '{16'h1D45, 16'h1F10, 16'h1C20, 16'h1E90,
                                           16'h1C5F, 16'h1C60, 16'h1F10};
   localparam logic        T_EXT [0:6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
   localparam logic [11:0] T_ADR [0:6] = '{12'h345, 12'h310, 12'h020, 12'hF90,
                                           12'h25F, 12'h060, 12'h310};
   localparam logic [7:0]  T_DAT [0:6] = '{8'h13, 8'hFF, 8'h5A, 8'h80, 8'h3C, 8'hC3, 8'h01};

   // ----------------------------------------------------------------
   // Design and memory partner
   // ----------------------------------------------------------------
   kick_invert_exec dut_u (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .phase_q1_o(phase_q1_o), .index_base_i(index_base_i),
      .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .work_o(work_o), .neg_o(neg_o), .zero_o(zero_o),
      .watchdog_expired_flag_o(exp_o), .sleep_entered_flag_o(slp_o),
      .watchdog_timeout_o(wto_o));
   data_mem_model mem_u (.req_i(mem_req_o), .core_clk_i(core_clk_i), .rdata_o(mem_rdata_i));

   // Clock at 50 MHz
   initial begin
      forever #10 core_clk_i = ~core_clk_i;
   end

   // Hang guard, and a count of watchdog timeout pulses
   always @(posedge core_clk_i) begin
      cyc++;
      if (wto_o === 1'b1) begin
         tout_seen++;
      end
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   // One-cycle register write
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask : reg_wr

   // Register read, data taken in the cycle after the strobe
   task automatic reg_chk(input logic [3:0] a, input logic [7:0] e);
      reg_addr_i <= a; reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
      rd_v = reg_rdata_o;
      `CHK(rd_v, e)
   endtask : reg_chk

   // Return just after the edge that starts a Q1 cycle
   task automatic sync();
      do @(posedge core_clk_i); while (phase_q1_o !== 1'b1);
      repeat (3) @(posedge core_clk_i);
   endtask : sync

   // Offer a word in Q1, return at the start of the next Q1
   task automatic issue(input logic [15:0] w);
      instr_valid_i <= 1'b1; instr_i <= w;
      @(posedge core_clk_i);
      instr_valid_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
   endtask : issue

   task automatic idle();
      repeat (4) @(posedge core_clk_i);
   endtask : idle

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge core_clk_i);
      srst_i <= 1'b0;
      @(posedge core_clk_i);
      // Reset values, access kinds, unmapped place
      reg_chk(exec_pkg::REG_CTRL, 8'h00);
      reg_chk(exec_pkg::REG_STATUS, 8'h0C);
      reg_chk(4'hF, 8'h00);
      reg_wr(exec_pkg::REG_WORK, 8'h55);
      reg_chk(exec_pkg::REG_WORK, 8'h00);
      reg_wr(exec_pkg::REG_BANK, 8'h03);
      reg_chk(exec_pkg::REG_BANK, 8'h03);
      $display("test registers done");
      // Invert cases over destination, access bank, indexed offset
      exp_w = 8'h00;
      for (int i = 0; i < 7; i++) begin
         reg_wr(exec_pkg::REG_CTRL, {7'h00, T_EXT[i]});
         mem_u.mem_r[T_ADR[i]] = T_DAT[i];
         dat = ~T_DAT[i];
         exp_f = T_INS[i][exec_pkg::DEST_BIT] ? T_DAT[i] : dat;
         if (T_INS[i][exec_pkg::DEST_BIT]) exp_w = dat;
         sync();
         issue(T_INS[i]);
         idle();
         `CHK(mem_u.mem_r[T_ADR[i]], exp_f)
         `CHK(work_o, exp_w)
         `CHK({neg_o, zero_o}, {dat[7], dat == 8'h00})
      end
      $display("test invert done");
      // Word offered outside Q1 is ignored
      reg_wr(exec_pkg::REG_CTRL, 8'h00);
      sync();
      @(posedge core_clk_i);
      instr_valid_i <= 1'b1; instr_i <= 16'h1C20;
      repeat (3) @(posedge core_clk_i);
      instr_valid_i <= 1'b0;
      idle();
      `CHK(mem_u.mem_r[12'h020], 8'hA5)
      // Back-to-back inverts in consecutive slots, then a word of neither kind
      mem_u.mem_r[12'h345] = 8'h0F;
      issue(16'h1D45);
      issue(16'h1C20);
      issue(16'h1820);
      idle();
      `CHK(mem_u.mem_r[12'h345], 8'hF0)
      `CHK(mem_u.mem_r[12'h020], 8'h5A)
      $display("test back to back done");
      // Watchdog expiry, then kick followed directly by an invert
      repeat (4300) @(posedge core_clk_i);
      `CHK(exp_o, 1'b0)
      `CHK(tout_seen, 1)
      sync();
      issue(exec_pkg::OPC_KICK);
      issue(16'h1D45);
      idle();
      `CHK({exp_o, slp_o}, 2'b11)
      `CHK(mem_u.mem_r[12'h345], 8'h0F)
      reg_chk(exec_pkg::REG_WPOST, 8'h00);
      reg_wr(exec_pkg::REG_CTRL, 8'h00);
      // Kick zeroed the count three cycles after its Q1; sampled twelve cycles later
      reg_chk(exec_pkg::REG_WDOG, 8'h0C);
      `CHK(tout_seen, 1)
      $display("test watchdog kick done");
      stop_test();
   end
endmodule : test_watchdog_clear_and_complement_exec
